// [memgame.sv]
// Sequence memory game core: shows, checks, times and scores a colour sequence.
// Assumes buttons are active high with external pull-downs, lamps active high.
// Overview of operation
// - Start button begins new game, clears sequence, presents first move.
// - First move lights one random lamp for half a second.
// - Wait up to five seconds for a press, else end the game.
// - After full repeat, append random colour and replay whole sequence.
// - Each press compared with stored colour, in presented order.
// - A wrong press ends the game at once.
// - Memory holds 32 moves; game ends when full.
// - Every correct press restarts the response timeout.
// - If colours remain, the end-of-game timer restarts for next press.
// - High score kept across games, cleared only by reset.
// - New high score: update it, pulse red, yellow, green, blue.
// - No new high score: pulse blue, green, yellow, red.
// - Lamp lit while presented and while player holds matching button.
// - Lamp and button bits 0..3 are red, yellow, green, blue.
`timescale 1ns/1ps
`default_nettype none
`include "memgame_defs.svh"
module memgame #(
  parameter int SHOW_CYC = `SHOW_CYC,
  parameter int WAIT_CYC = `WAIT_CYC,
  parameter int GAP_CYC = `GAP_CYC,
  parameter int DEB_CYC = `DEB_CYC,
  parameter int MAX_MOVES = `MAX_MOVES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Player inputs
  input wire memgame_pkg::buttons_t buttons,
  // Lamps, score and game-in-progress flag
  output logic [3:0] lamp,
  output logic [5:0] high_score,
  output logic playing
);
  import memgame_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SHOW, ST_GAP, ST_WAIT, ST_RELEASE, ST_END
  } state_t;

  localparam int PW = $clog2(MAX_MOVES + 1);

  buttons_t clean;
  state_t state_ff;
  logic [31:0] timer_ff;
  logic [PW-1:0] len_ff;
  logic [PW-1:0] pos_ff;
  colour_t seq_ff [MAX_MOVES];
  logic [15:0] lfsr_ff;
  logic [3:0] lamp_ff;
  logic [5:0] high_ff;
  logic [2:0] end_step_ff;
  logic win_ff;
  logic start_q_ff;
  logic [3:0] held_ff;
  logic playing_ff;
  logic start_edge;
  logic press;
  colour_t press_col;
  colour_t rnd_col;
  logic timer_done;
  logic end_game;

  // Buttons pass through synchroniser and debouncer
  btn_debounce #(.WIDTH(5), .STABLE_CYC(DEB_CYC)) u_deb (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .raw_in(buttons),
    .clean_out(clean)
  );

  // Edge and press decode; lowest set bit wins for simultaneous presses
  assign start_edge = clean.start & ~start_q_ff;
  assign press = (clean.colour != 4'h0) && (held_ff == 4'h0);
  assign press_col = clean.colour[`LAMP_RED] ? colour_t'(`LAMP_RED) :
                     clean.colour[`LAMP_YEL] ? colour_t'(`LAMP_YEL) :
                     clean.colour[`LAMP_GRN] ? colour_t'(`LAMP_GRN) :
                     colour_t'(`LAMP_BLU);
  assign rnd_col = lfsr_ff[1:0];
  assign timer_done = (timer_ff == 32'd0);
  assign end_game = (state_ff == ST_WAIT) && (timer_done ||
                    (press && press_col != seq_ff[pos_ff[PW-2:0]]));

  // Free-running pseudo-random source
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      lfsr_ff <= `LFSR_SEED;
    end else begin
      lfsr_ff <= {1'b0, lfsr_ff[15:1]} ^ (lfsr_ff[0] ? `LFSR_TAPS : 16'h0000);
    end
  end

  // Input history for edge detection
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      start_q_ff <= 1'b0;
      held_ff <= 4'h0;
    end else begin
      start_q_ff <= clean.start;
      held_ff <= clean.colour;
    end
  end

  // Game sequencer
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
      timer_ff <= '0;
      len_ff <= '0;
      pos_ff <= '0;
      end_step_ff <= '0;
      win_ff <= 1'b0;
    end else if (start_edge) begin
      state_ff <= ST_SHOW;
      len_ff <= PW'(1);
      pos_ff <= '0;
      timer_ff <= 32'(SHOW_CYC - 1);
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          timer_ff <= '0;
        end
        ST_SHOW: begin
          if (!timer_done) begin
            timer_ff <= timer_ff - 32'd1;
          end else begin
            state_ff <= ST_GAP;
            timer_ff <= 32'(GAP_CYC - 1);
          end
        end
        ST_GAP: begin
          if (!timer_done) begin
            timer_ff <= timer_ff - 32'd1;
          end else if (pos_ff + PW'(1) < len_ff) begin
            state_ff <= ST_SHOW;
            pos_ff <= pos_ff + PW'(1);
            timer_ff <= 32'(SHOW_CYC - 1);
          end else begin
            state_ff <= ST_WAIT;
            pos_ff <= '0;
            timer_ff <= 32'(WAIT_CYC - 1);
          end
        end
        ST_WAIT: begin
          if (end_game) begin
            state_ff <= ST_END;
            win_ff <= (6'(len_ff - PW'(1)) > high_ff);
            end_step_ff <= '0;
            timer_ff <= 32'(SHOW_CYC - 1);
          end else if (press) begin
            state_ff <= ST_RELEASE;
            timer_ff <= 32'(WAIT_CYC - 1);
          end else begin
            timer_ff <= timer_ff - 32'd1;
          end
        end
        ST_RELEASE: begin
          if (clean.colour == 4'h0) begin
            if (pos_ff + PW'(1) < len_ff) begin
              state_ff <= ST_WAIT;
              pos_ff <= pos_ff + PW'(1);
              timer_ff <= 32'(WAIT_CYC - 1);
            end else if (len_ff == PW'(MAX_MOVES)) begin
              state_ff <= ST_END;
              win_ff <= (6'(len_ff) > high_ff);
              end_step_ff <= '0;
              timer_ff <= 32'(SHOW_CYC - 1);
            end else begin
              state_ff <= ST_SHOW;
              len_ff <= len_ff + PW'(1);
              pos_ff <= '0;
              timer_ff <= 32'(SHOW_CYC - 1);
            end
          end else if (!timer_done) begin
            timer_ff <= timer_ff - 32'd1;
          end else begin
            state_ff <= ST_END;
            win_ff <= (6'(pos_ff) > high_ff);
            end_step_ff <= '0;
            timer_ff <= 32'(SHOW_CYC - 1);
          end
        end
        ST_END: begin
          if (!timer_done) begin
            timer_ff <= timer_ff - 32'd1;
          end else if (end_step_ff == 3'(`END_STEPS - 1)) begin
            state_ff <= ST_IDLE;
          end else begin
            end_step_ff <= end_step_ff + 3'd1;
            timer_ff <= 32'(SHOW_CYC - 1);
          end
        end
      endcase
    end
  end

  // Sequence memory: new colour drawn at start and when the sequence grows after a full repeat
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < MAX_MOVES; i++) begin
        seq_ff[i] <= colour_t'(0);
      end
    end else if (start_edge) begin
      seq_ff[0] <= rnd_col;
    end else if (state_ff == ST_RELEASE && clean.colour == 4'h0 &&
                 pos_ff + PW'(1) >= len_ff && len_ff < PW'(MAX_MOVES)) begin
      seq_ff[len_ff[PW-2:0]] <= rnd_col;
    end
  end

  // High score survives new games
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      high_ff <= '0;
    end else if (state_ff == ST_WAIT && end_game &&
                 6'(len_ff - PW'(1)) > high_ff) begin
      high_ff <= 6'(len_ff - PW'(1));
    end else if (state_ff == ST_RELEASE && clean.colour == 4'h0 &&
                 len_ff == PW'(MAX_MOVES) && pos_ff + PW'(1) >= len_ff &&
                 6'(len_ff) > high_ff) begin
      high_ff <= 6'(len_ff);
    end else if (state_ff == ST_RELEASE && clean.colour != 4'h0 && timer_done &&
                 6'(pos_ff) > high_ff) begin
      high_ff <= 6'(pos_ff);
    end
  end

  // Lamp drive: shown colour, held buttons, end pattern
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      lamp_ff <= 4'h0;
    end else begin
      unique case (state_ff)
        ST_SHOW: lamp_ff <= 4'h1 << seq_ff[pos_ff[PW-2:0]];
        ST_WAIT, ST_RELEASE: lamp_ff <= clean.colour;
        ST_END: begin
          if (end_step_ff[0]) begin
            lamp_ff <= 4'h0;
          end else if (win_ff) begin
            lamp_ff <= 4'h1 << end_step_ff[2:1];
          end else begin
            lamp_ff <= 4'h8 >> end_step_ff[2:1];
          end
        end
        default: lamp_ff <= 4'h0;
      endcase
    end
  end

  // Game-in-progress flag, registered so the pin comes from a flip-flop; one cycle behind state
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      playing_ff <= 1'b0;
    end else begin
      playing_ff <= (state_ff != ST_IDLE) && (state_ff != ST_END);
    end
  end

  assign lamp = lamp_ff;
  assign high_score = high_ff;
  assign playing = playing_ff;

  AST_WAIT_BOUND: assert property (@(posedge core_clk) disable iff (!reset_n)
    timer_ff <= 32'(WAIT_CYC - 1)) else $error("timer beyond wait");
  AST_WRONG_ENDS: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_ff == ST_WAIT && !start_edge && press && !timer_done &&
     press_col != seq_ff[pos_ff[PW-2:0]]) |=> state_ff == ST_END)
    else $error("wrong press did not end");
  AST_LEN_MAX: assert property (@(posedge core_clk) disable iff (!reset_n)
    len_ff <= PW'(MAX_MOVES)) else $error("sequence too long");
  AST_RESTART: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_ff == ST_WAIT && press && !end_game && !start_edge) |=>
    timer_ff == 32'(WAIT_CYC - 1)) else $error("timeout not restarted");
  AST_HIGH_MONO: assert property (@(posedge core_clk) disable iff (!reset_n)
    high_ff >= $past(high_ff)) else $error("high score fell");
  AST_START: assert property (@(posedge core_clk) disable iff (!reset_n)
    start_edge |=> state_ff == ST_SHOW && len_ff == PW'(1))
    else $error("start failed");
  AST_SHOW_ONE: assert property (@(posedge core_clk) disable iff (!reset_n)
    $past(state_ff) == ST_SHOW && state_ff == ST_SHOW |-> $onehot(lamp_ff))
    else $error("show lamp not one-hot");
  AST_END_PATTERN: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_ff == ST_END && end_step_ff == 3'd0 && $past(state_ff) == ST_END) |->
    lamp_ff == (win_ff ? 4'h1 : 4'h8)) else $error("end pattern wrong");
  COV_START: cover property (@(posedge core_clk) start_edge);
  COV_GROW: cover property (@(posedge core_clk) len_ff == PW'(3));
  COV_WIN: cover property (@(posedge core_clk) state_ff == ST_END && win_ff);
endmodule // memgame
`default_nettype wire

// [memgame_defs.svh]
// Constants for the sequence memory game: timing, sizes and lamp layout.
// Assumes a single system clock; counts derived from its rate.
`ifndef MEMGAME_DEFS_SVH
`define MEMGAME_DEFS_SVH
`define CLK_HZ 125_000_000
`define SHOW_MS 500
`define WAIT_MS 5000
`define GAP_MS 100
`define DEB_US 1000
`define SHOW_CYC ((`CLK_HZ / 1000) * `SHOW_MS)
`define WAIT_CYC ((`CLK_HZ / 1000) * `WAIT_MS)
`define GAP_CYC ((`CLK_HZ / 1000) * `GAP_MS)
`define DEB_CYC ((`CLK_HZ / 1000_000) * `DEB_US)
`define MAX_MOVES 32
`define END_STEPS 8
`define LAMP_RED 0
`define LAMP_YEL 1
`define LAMP_GRN 2
`define LAMP_BLU 3
`define LFSR_SEED 16'hACE1
`define LFSR_TAPS 16'hB400
`endif

// [memgame_pkg.sv]
// Types shared by the sequence memory game files.
// Assumes memgame_defs.svh supplies the numeric constants.
`default_nettype none
package memgame_pkg;
  typedef logic [1:0] colour_t;
  typedef struct packed {
    logic start;
    logic [3:0] colour;
  } buttons_t;
endpackage
`default_nettype wire

// [btn_debounce.sv]
// Synchroniser and debouncer for one group of push buttons.
// Assumes raw inputs are slow mechanical contacts on core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "memgame_defs.svh"
module btn_debounce #(
  parameter int WIDTH = 5,
  parameter int STABLE_CYC = `DEB_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Buttons
  input wire logic [WIDTH-1:0] raw_in,
  output logic [WIDTH-1:0] clean_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // Two-stage synchroniser; the first stage feeds only the second
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= raw_in;
      sync_ff <= meta_ff;
    end
  end

  // One stability counter per button
  for (genvar i = 0; i < WIDTH; i++) begin : g_deb
    logic [31:0] cnt_ff;
    logic clean_ff;
    always_ff @(posedge core_clk) begin
      if (!reset_n) begin
        cnt_ff <= '0;
        clean_ff <= 1'b0;
      end else if (sync_ff[i] == clean_ff) begin
        cnt_ff <= '0;
      end else if (cnt_ff >= 32'(STABLE_CYC - 1)) begin
        cnt_ff <= '0;
        clean_ff <= sync_ff[i];
      end else begin
        cnt_ff <= cnt_ff + 32'd1;
      end
    end
    assign clean_out[i] = clean_ff;
  end
endmodule // btn_debounce
`default_nettype wire

// [memgame_player.sv]
// Player model for the memory game: presses start and colour buttons, watches the lamps.
// Assumes buttons read low when released and lamps that light active high.
`timescale 1ns/1ps
`default_nettype none
module memgame_player #(
  parameter int GAP_CYC = 5
) (
  // Clock
  input wire logic core_clk,
  // Lamps seen
  input wire logic [3:0] lamp,
  // Buttons driven
  output var memgame_pkg::buttons_t buttons
);
  import memgame_pkg::*;
  logic [3:0] shown [32];
  logic [3:0] held_lamp;
  int on_len;

  // Released buttons are pulled down
  initial buttons = '0;

  // Press a button group, note the lamp while held, then release all
  task automatic push(input logic [4:0] b);
    @(posedge core_clk);
    #1 buttons = buttons_t'(b);
    repeat (8) @(posedge core_clk);
    held_lamp = lamp;
    #1 buttons = '0;
    repeat (8) @(posedge core_clk);
  endtask

  // Record n lamp pulses; keep the on time of the last one
  task automatic watch(input int n);
    int t;
    for (int i = 0; i < n; i++) begin
      for (t = 0; t < 400 && lamp == 4'h0; t++) @(posedge core_clk);
      shown[i] = lamp;
      for (t = 0; t < 400 && lamp != 4'h0; t++) @(posedge core_clk);
      on_len = t;
    end
  endtask

  // Repeat the shown sequence; at position bad press a wrong colour and stop
  task automatic echo(input int n, input int bad);
    repeat (GAP_CYC + 3) @(posedge core_clk);
    for (int i = 0; i < n; i++) begin
      if (i == bad) begin
        push({1'b0, shown[i][2:0], shown[i][3]});
        return;
      end
      push({1'b0, shown[i]});
    end
  endtask
endmodule // memgame_player
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the memory game: error, timeout and full-memory games.
// Assumes the player model drives all buttons; short counts set through parameters.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import memgame_pkg::*;
  localparam int SHOW = 20;
  logic core_clk;
  logic reset_n;
  buttons_t buttons;
  logic [3:0] lamp;
  logic [5:0] high_score;
  logic playing;
  int failures;
  int checks_done;
  int cyc;
  logic [3:0] keep [32];

  // Design with shortened intervals
  memgame #(.SHOW_CYC(SHOW), .WAIT_CYC(100), .GAP_CYC(5), .DEB_CYC(2)) dut (
    .core_clk(core_clk), .reset_n(reset_n), .buttons(buttons),
    .lamp(lamp), .high_score(high_score), .playing(playing));

  // Player at the buttons and lamps; its default gap matches the design's gap above
  memgame_player pl (.core_clk(core_clk), .lamp(lamp), .buttons(buttons));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Wait a bounded time for the game to stop
  task automatic wait_end();
    for (int t = 0; t < 200 && playing !== 1'b0; t++) @(posedge core_clk);
    check(playing, 1'b0);
  endtask

  // Judge the end pattern and the stored best score
  task automatic ending(input bit win, input logic [5:0] best);
    pl.watch(4);
    for (int i = 0; i < 4; i++)
      check(pl.shown[i], win ? 4'h1 << i : 4'h8 >> i);
    repeat (150) @(posedge core_clk);
    check(high_score, best);
  endtask

  task automatic start_game();
    pl.push(5'h10);
    check(playing, 1'b1);
  endtask

  // One round: replayed prefix must match, new colour one-hot, then repeat it
  task automatic round(input int k, input int bad);
    pl.watch(k);
    for (int i = 0; i < k - 1; i++)
      check(pl.shown[i], keep[i]);
    check(8'($countones(pl.shown[k-1])), 8'h01);
    for (int i = 0; i < k; i++)
      keep[i] = pl.shown[i];
    pl.echo(k, bad);
    if (bad < 0)
      check(pl.held_lamp, pl.shown[k-1]);
  endtask

  task automatic t_reset();
    check(lamp, 4'h0);
    check(high_score, 6'h00);
    check(playing, 1'b0);
  endtask

  task automatic t_error();
    start_game();
    for (int k = 1; k <= 3; k++)
      round(k, -1);
    check(8'(pl.on_len), 8'(SHOW));
    round(4, 1);
    check(playing, 1'b0);
    ending(1'b1, 6'h03);
  endtask

  task automatic t_timeout();
    start_game();
    check(high_score, 6'h03);
    round(1, -1);
    round(2, -1);
    pl.watch(3);
    repeat (60) @(posedge core_clk);
    pl.push({1'b0, pl.shown[0]});
    repeat (60) @(posedge core_clk);
    check(playing, 1'b1);
    wait_end();
    ending(1'b0, 6'h03);
  endtask

  task automatic t_full();
    start_game();
    for (int k = 1; k <= 32; k++)
      round(k, -1);
    wait_end();
    ending(1'b1, 6'h20);
  endtask

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      give_verdict();
    end
  end

  // Main sequence
  initial begin
    reset_n = 1'b0;
    repeat (10) @(posedge core_clk);
    #1 reset_n = 1'b1;
    t_reset();
    t_error();
    t_timeout();
    t_full();
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
